// File: hdl/wake_cfg_pkg.sv
package wake_cfg_pkg;

  localparam logic [7:0] CFG_OFFSET   = 8'h08;
  localparam logic [7:0] MASK_OFFSET  = 8'h09;

  localparam logic [7:0] CFG_RESET    = 8'h67;
  localparam logic [7:0] MASK_RESET   = 8'h5F;
  localparam logic [7:0] CFG_WR_MASK  = 8'hF7;
  localparam logic [7:0] MASK_WR_MASK = 8'h5F;

  localparam int CFG_CRIT_BIT   = 7;
  localparam int CFG_STP_DIS    = 6;
  localparam int CFG_SUPER_BIT  = 5;
  localparam int CFG_PD_BIT     = 4;
  localparam int CFG_DLY_LSB    = 0;
  localparam int DLY_W          = 3;

  localparam int FLAG_LIN       = 6;
  localparam int FLAG_ONSW      = 4;
  localparam int FLAG_STATUS    = 3;
  localparam int FLAG_NET       = 2;
  localparam int FLAG_TEMP      = 1;
  localparam int FLAG_VOLT      = 0;

  // order of the pin levels inside the synchroniser vector
  localparam int PIN_LIN        = 0;
  localparam int PIN_ONSW       = 1;
  localparam int PIN_STATUS     = 2;
  localparam int PIN_NET        = 3;
  localparam int PIN_SUPER      = 4;
  localparam int PIN_CRIT       = 5;
  localparam int PIN_LOW        = 6;
  localparam int PIN_SUPPLY_OK  = 7;
  localparam int PIN_STRAP      = 8;
  localparam int PIN_COUNT      = 9;

  localparam logic [1:0] STRAP_WAIT_RESET = 2'h3;
  localparam logic [1:0] CHG_PRIME_RESET  = 2'h3;

  localparam int unsigned CLK_FREQ_KHZ = 10000;
  localparam int unsigned RST_DELAY_US [8] =
    '{1200, 2000, 3000, 4000, 5000, 6000, 8000, 10000};

  function automatic int unsigned delay_cycles(input int unsigned us);
    int unsigned c;
    c = us * CLK_FREQ_KHZ / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned RST_DELAY_CYC_DEFAULT [8] = '{
    delay_cycles(RST_DELAY_US[0]), delay_cycles(RST_DELAY_US[1]),
    delay_cycles(RST_DELAY_US[2]), delay_cycles(RST_DELAY_US[3]),
    delay_cycles(RST_DELAY_US[4]), delay_cycles(RST_DELAY_US[5]),
    delay_cycles(RST_DELAY_US[6]), delay_cycles(RST_DELAY_US[7])};

  typedef enum logic [1:0] {
    RST_HELD,
    RST_COUNT,
    RST_RELEASED
  } rst_state_type;

endpackage

// File: hdl/level_change_if.sv
`timescale 1ns/10ps
interface level_change_if #(
  parameter int N = 9
);
  logic [N-1:0] level;
  logic [N-1:0] change;
  logic         primed;

  modport src (output level, output change, output primed);
  modport dst (input level, input change, input primed);
endinterface

// File: hdl/pin_change_detect.sv
`timescale 1ns/10ps
module pin_change_detect #(
  parameter int N = 9
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [N-1:0] pin_i,
  level_change_if.src       chg
);

  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;
  logic [N-1:0] prev_reg;
  logic [1:0]   prime_reg;

  // meta_reg feeds sync_reg only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_reg  <= '0;
      prime_reg <= wake_cfg_pkg::CHG_PRIME_RESET;
    end else begin
      prev_reg  <= sync_reg;
      if (prime_reg != 2'h0) begin
        prime_reg <= prime_reg - 2'h1;
      end
    end
  end

  // no change is reported until the chain holds real pin levels
  assign chg.level  = sync_reg;
  assign chg.primed = (prime_reg == 2'h0);
  assign chg.change = chg.primed ? (sync_reg ^ prev_reg) : '0;

endmodule

// File: hdl/wake_config_and_irq_mask.sv
`timescale 1ns/10ps
module wake_config_and_irq_mask #(
  parameter int          CNT_W = 17,
  parameter int unsigned RST_DELAY_CYC [8] =
    wake_cfg_pkg::RST_DELAY_CYC_DEFAULT
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // register port of the control interface
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // pins and analog comparator levels
  input  wire logic       wake_level_strap_pin_i,
  input  wire logic       lin_level_i,
  input  wire logic       on_switch_level_i,
  input  wire logic       status_pin_level_i,
  input  wire logic       network_activity_level_i,
  input  wire logic       super_voltage_status_i,
  input  wire logic       critical_voltage_status_i,
  input  wire logic       low_voltage_status_i,
  input  wire logic       reset_monitored_supply_ok_i,
  // same-clock inputs from neighbouring logic
  input  wire logic [1:0] low_threshold_select_i,
  input  wire logic [1:0] critical_threshold_select_i,
  input  wire logic       temperature_cross_i,
  input  wire logic       switch_power_event_i,
  input  wire logic       network_wake_cause_i,
  input  wire logic [2:0] general_reset_delay_i,
  input  wire logic [7:0] flag_clear_i,
  // outputs
  output logic            wake_permit_o,
  output logic      [1:0] wake_min_threshold_sel_o,
  output logic            wake_upper_bound_en_o,
  output logic            power_applied_event_o,
  output logic            network_detector_powerdown_o,
  output logic            host_reset_n_o,
  output logic      [7:0] event_flags_o,
  output logic            host_irq_n_o
);

  level_change_if #(.N(wake_cfg_pkg::PIN_COUNT)) pins ();

  logic [wake_cfg_pkg::PIN_COUNT-1:0] pin_raw;

  assign pin_raw[wake_cfg_pkg::PIN_LIN]       = lin_level_i;
  assign pin_raw[wake_cfg_pkg::PIN_ONSW]      = on_switch_level_i;
  assign pin_raw[wake_cfg_pkg::PIN_STATUS]    = status_pin_level_i;
  assign pin_raw[wake_cfg_pkg::PIN_NET]       = network_activity_level_i;
  assign pin_raw[wake_cfg_pkg::PIN_SUPER]     = super_voltage_status_i;
  assign pin_raw[wake_cfg_pkg::PIN_CRIT]      = critical_voltage_status_i;
  assign pin_raw[wake_cfg_pkg::PIN_LOW]       = low_voltage_status_i;
  assign pin_raw[wake_cfg_pkg::PIN_SUPPLY_OK] = reset_monitored_supply_ok_i;
  assign pin_raw[wake_cfg_pkg::PIN_STRAP]     = wake_level_strap_pin_i;

  pin_change_detect #(
    .N(wake_cfg_pkg::PIN_COUNT)
  ) u_pins (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pin_i  (pin_raw),
    .chg    (pins.src)
  );

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic       cfg_sel;
  logic       mask_sel;
  logic       cfg_wr;
  logic       mask_wr;

  // offsets decode on the address alone; the strobes qualify below
  assign cfg_sel  = (reg_addr_i == wake_cfg_pkg::CFG_OFFSET);
  assign mask_sel = (reg_addr_i == wake_cfg_pkg::MASK_OFFSET);
  assign cfg_wr   = reg_wr_i & cfg_sel;
  assign mask_wr  = reg_wr_i & mask_sel;

  // ---------------------------------------------------------------
  // configuration register with strap capture
  // ---------------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] cfg_written;
  logic [1:0] strap_wait_reg;
  logic [1:0] strap_wait_next;
  logic       strap_load;

  // the strap is read through the synchroniser a few edges after
  // release, so a floating pin during reset never reaches the bit
  assign strap_load      = (strap_wait_reg == 2'h1);
  assign strap_wait_next = (strap_wait_reg != 2'h0) ?
                           strap_wait_reg - 2'h1 : 2'h0;

  assign cfg_written = cfg_wr ?
                       (reg_wdata_i & wake_cfg_pkg::CFG_WR_MASK) :
                       cfg_reg;

  always_comb begin
    cfg_next = cfg_written;
    if (strap_load) begin
      cfg_next[wake_cfg_pkg::CFG_CRIT_BIT] =
        pins.level[wake_cfg_pkg::PIN_STRAP];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_reg        <= wake_cfg_pkg::CFG_RESET;
      strap_wait_reg <= wake_cfg_pkg::STRAP_WAIT_RESET;
    end else begin
      cfg_reg        <= cfg_next;
      strap_wait_reg <= strap_wait_next;
    end
  end

  localparam int DLY_W = wake_cfg_pkg::DLY_W;

  logic             crit_ctl;
  logic             stp_disable;
  logic             super_allow;
  logic [DLY_W-1:0] net_delay_sel;

  assign crit_ctl      = cfg_reg[wake_cfg_pkg::CFG_CRIT_BIT];
  assign stp_disable   = cfg_reg[wake_cfg_pkg::CFG_STP_DIS];
  assign super_allow   = cfg_reg[wake_cfg_pkg::CFG_SUPER_BIT];
  assign net_delay_sel =
    cfg_reg[wake_cfg_pkg::CFG_DLY_LSB +: wake_cfg_pkg::DLY_W];

  // ---------------------------------------------------------------
  // mask register
  // ---------------------------------------------------------------
  logic [7:0] mask_reg;
  logic [7:0] mask_next;

  // the mask only gates the pin; the flags further down ignore it
  assign mask_next = mask_wr ?
                     (reg_wdata_i & wake_cfg_pkg::MASK_WR_MASK) :
                     mask_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_reg <= wake_cfg_pkg::MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // read data holds until the next read strobe
  // unmapped offsets read as zero
  assign rdata_next = cfg_sel  ? cfg_reg  :
                      mask_sel ? mask_reg : 8'h00;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ---------------------------------------------------------------
  // wakeup supply window
  // ---------------------------------------------------------------
  logic       in_low;
  logic       in_crit;
  logic       in_super;
  logic       permit_next;
  logic [1:0] min_sel_next;
  logic       permit_reg;
  logic [1:0] min_sel_reg;
  logic       upper_en_reg;

  assign in_low   = pins.level[wake_cfg_pkg::PIN_LOW];
  assign in_crit  = pins.level[wake_cfg_pkg::PIN_CRIT];
  assign in_super = pins.level[wake_cfg_pkg::PIN_SUPER];

  // critical region blocks wakeup only with the control bit set
  assign permit_next = ~in_low &
                       ~(in_crit & crit_ctl) &
                       ~(in_super & ~super_allow);
  assign min_sel_next = crit_ctl ? critical_threshold_select_i :
                        low_threshold_select_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      permit_reg   <= 1'b0;
      min_sel_reg  <= 2'h0;
      upper_en_reg <= 1'b0;
    end else begin
      // no permit until the synchroniser holds real supply levels
      permit_reg   <= permit_next & pins.primed;
      min_sel_reg  <= min_sel_next;
      upper_en_reg <= ~super_allow;
    end
  end

  assign wake_permit_o            = permit_reg;
  assign wake_min_threshold_sel_o = min_sel_reg;
  assign wake_upper_bound_en_o    = upper_en_reg;

  // ---------------------------------------------------------------
  // switch-to-power events and detector power
  // ---------------------------------------------------------------
  // one-cycle pulse only; the flag and wake cause live outside
  logic stp_pulse_reg;
  logic pd_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stp_pulse_reg <= 1'b0;
      pd_reg        <= 1'b0;
    end else begin
      stp_pulse_reg <= switch_power_event_i & ~stp_disable;
      pd_reg        <= cfg_reg[wake_cfg_pkg::CFG_PD_BIT];
    end
  end

  assign power_applied_event_o        = stp_pulse_reg;
  assign network_detector_powerdown_o = pd_reg;

  // ---------------------------------------------------------------
  // event flags and interrupt pin
  // ---------------------------------------------------------------
  logic [7:0] flag_reg;
  logic [7:0] flag_set;
  logic [7:0] flag_next;
  logic       irq_n_reg;
  logic       supply_change;

  assign supply_change = pins.change[wake_cfg_pkg::PIN_SUPER] |
                         pins.change[wake_cfg_pkg::PIN_CRIT] |
                         pins.change[wake_cfg_pkg::PIN_LOW];

  always_comb begin
    flag_set = 8'h00;
    flag_set[wake_cfg_pkg::FLAG_LIN] =
      pins.change[wake_cfg_pkg::PIN_LIN];
    flag_set[wake_cfg_pkg::FLAG_ONSW] =
      pins.change[wake_cfg_pkg::PIN_ONSW];
    flag_set[wake_cfg_pkg::FLAG_STATUS] =
      pins.change[wake_cfg_pkg::PIN_STATUS];
    flag_set[wake_cfg_pkg::FLAG_NET] =
      pins.change[wake_cfg_pkg::PIN_NET];
    flag_set[wake_cfg_pkg::FLAG_TEMP] = temperature_cross_i;
    flag_set[wake_cfg_pkg::FLAG_VOLT] = supply_change;
  end

  // a set in the same cycle as its clear wins; masks never touch flags
  assign flag_next = ((flag_reg & ~flag_clear_i) | flag_set) &
                     wake_cfg_pkg::MASK_WR_MASK;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_reg  <= 8'h00;
      irq_n_reg <= 1'b1;
    end else begin
      flag_reg  <= flag_next;
      // interrupt follows the flags with one cycle of lag
      irq_n_reg <= ~|(flag_reg & ~mask_reg);
    end
  end

  assign event_flags_o = flag_reg;
  assign host_irq_n_o  = irq_n_reg;

  // ---------------------------------------------------------------
  // reset generator
  // ---------------------------------------------------------------
  wake_cfg_pkg::rst_state_type rst_state_reg;
  wake_cfg_pkg::rst_state_type rst_state_next;
  logic [CNT_W-1:0] rst_cnt_reg;
  logic [CNT_W-1:0] rst_cnt_next;
  logic [2:0]       dly_sel;
  logic [CNT_W-1:0] dly_load;
  logic             supply_ok;
  logic             rst_n_reg;

  assign supply_ok = pins.level[wake_cfg_pkg::PIN_SUPPLY_OK] & pins.primed;
  assign dly_sel   = network_wake_cause_i ? net_delay_sel :
                     general_reset_delay_i;
  // loads delay minus one so the release lands on the last count
  assign dly_load  = CNT_W'(RST_DELAY_CYC[dly_sel] - 1);

  always_comb begin
    rst_state_next = rst_state_reg;
    rst_cnt_next   = rst_cnt_reg;
    case (rst_state_reg)
      wake_cfg_pkg::RST_HELD: begin
        if (supply_ok) begin
          rst_state_next = wake_cfg_pkg::RST_COUNT;
          rst_cnt_next   = dly_load;
        end
      end
      // a supply drop mid-count goes back to held and restarts the delay
      wake_cfg_pkg::RST_COUNT: begin
        if (!supply_ok) begin
          rst_state_next = wake_cfg_pkg::RST_HELD;
        end else if (rst_cnt_reg == '0) begin
          rst_state_next = wake_cfg_pkg::RST_RELEASED;
        end else begin
          rst_cnt_next = rst_cnt_reg - CNT_W'(1);
        end
      end
      wake_cfg_pkg::RST_RELEASED: begin
        if (!supply_ok) begin
          rst_state_next = wake_cfg_pkg::RST_HELD;
        end
      end
      default: begin
        rst_state_next = wake_cfg_pkg::RST_HELD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_state_reg <= wake_cfg_pkg::RST_HELD;
      rst_cnt_reg   <= '0;
      rst_n_reg     <= 1'b0;
    end else begin
      rst_state_reg <= rst_state_next;
      rst_cnt_reg   <= rst_cnt_next;
      rst_n_reg     <= (rst_state_next == wake_cfg_pkg::RST_RELEASED);
    end
  end

  assign host_reset_n_o = rst_n_reg;

endmodule

// File: tb/wake_config_and_irq_mask_assertions.sv
`timescale 1ns/10ps
module wake_config_and_irq_mask_assertions (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reset_monitored_supply_ok_i,
  input wire logic       temperature_cross_i,
  input wire logic       switch_power_event_i,
  input wire logic [7:0] flag_clear_i,
  input wire logic       wake_upper_bound_en_o,
  input wire logic       power_applied_event_o,
  input wire logic       network_detector_powerdown_o,
  input wire logic       host_reset_n_o,
  input wire logic [7:0] event_flags_o,
  input wire logic       host_irq_n_o
);
  logic [7:0] cfg_reg;
  logic [7:0] msk_reg;
  wire        cfg_wr = reg_wr_i && reg_addr_i == 8'h08;
  wire        msk_wr = reg_wr_i && reg_addr_i == 8'h09;
  wire        unmap = reg_addr_i != 8'h08 && reg_addr_i != 8'h09;
  wire        pend = |(event_flags_o & ~msk_reg);
  // shadow copy; bit7 is never used since the strap may overwrite it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_reg <= 8'h67;
      msk_reg <= 8'h5F;
    end else begin
      if (cfg_wr) cfg_reg <= reg_wdata_i & 8'hF7;
      if (msk_wr) msk_reg <= reg_wdata_i & 8'h5F;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_irq_low: assert property (pend |=> !host_irq_n_o)
    else $error("irq not asserted");
  a_irq_high: assert property (!pend |=> host_irq_n_o)
    else $error("masked irq asserted");
  a_flag_sticky: assert property (1'b1 |=>
    (($past(event_flags_o) & ~$past(flag_clear_i)) & ~event_flags_o) == 8'h00)
    else $error("flag dropped");
  a_temp_flag: assert property (temperature_cross_i |=> event_flags_o[1])
    else $error("temperature flag missing");
  a_stp_on: assert property (switch_power_event_i && !cfg_reg[6] |=>
    power_applied_event_o) else $error("stp pulse missing");
  a_stp_off: assert property (!switch_power_event_i || cfg_reg[6] |=>
    !power_applied_event_o) else $error("stp pulse unexpected");
  a_pd_copy: assert property (cfg_wr |-> ##2
    network_detector_powerdown_o == $past(reg_wdata_i[4], 2))
    else $error("powerdown wrong");
  a_upper_bound: assert property (cfg_wr |-> ##2
    wake_upper_bound_en_o == !$past(reg_wdata_i[5], 2))
    else $error("upper bound wrong");
  a_mask_read: assert property (reg_rd_i && reg_addr_i == 8'h09 |=>
    reg_rdata_o == $past(msk_reg)) else $error("mask read wrong");
  a_unmap_read: assert property (reg_rd_i && unmap |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_reset_low: assert property (!reset_monitored_supply_ok_i [*5] |->
    !host_reset_n_o) else $error("reset released early");
  c_irq: cover property (!host_irq_n_o);
  c_stp: cover property (power_applied_event_o);
  c_rel: cover property ($rose(host_reset_n_o));
endmodule
bind wake_config_and_irq_mask wake_config_and_irq_mask_assertions u_chk (
  .clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
  .reg_rdata_o, .reset_monitored_supply_ok_i, .temperature_cross_i,
  .switch_power_event_i, .flag_clear_i, .wake_upper_bound_en_o,
  .power_applied_event_o, .network_detector_powerdown_o, .host_reset_n_o,
  .event_flags_o, .host_irq_n_o);

// File: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o = 8'h00,
  output logic            wr_o = 1'b0,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            rd_o = 1'b0
);
  // one strobe cycle per access; the strobe drops on the edge that took it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// File: tb/wake_config_and_irq_mask_tb.sv
`timescale 1ns/10ps
module wake_config_and_irq_mask_tb;
  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, event_flags_o;
  logic       reg_wr_i, reg_rd_i;
  logic       wake_level_strap_pin_i = 1'b1;
  logic       lin_level_i = 1'b0;
  logic       on_switch_level_i = 1'b0;
  logic       status_pin_level_i = 1'b0;
  logic       network_activity_level_i = 1'b0;
  logic       super_voltage_status_i = 1'b0;
  logic       critical_voltage_status_i = 1'b0;
  logic       low_voltage_status_i = 1'b0;
  logic       reset_monitored_supply_ok_i = 1'b1;
  logic [1:0] low_threshold_select_i = 2'h1;
  logic [1:0] critical_threshold_select_i = 2'h2;
  logic       temperature_cross_i = 1'b0;
  logic       switch_power_event_i = 1'b0;
  logic       network_wake_cause_i = 1'b0;
  logic [2:0] general_reset_delay_i = 3'h0;
  logic [7:0] flag_clear_i = 8'h00;
  logic       wake_permit_o, wake_upper_bound_en_o, power_applied_event_o;
  logic [1:0] wake_min_threshold_sel_o;
  logic       network_detector_powerdown_o, host_reset_n_o, host_irq_n_o;
  int         num_errors = 0;
  int         samples_checked = 0;

  always #50 clk_i = ~clk_i;

  // short delay table keeps the reset generator runs brief
  wake_config_and_irq_mask #(.RST_DELAY_CYC('{3, 4, 5, 6, 7, 8, 9, 10})) dut (
    .clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .wake_level_strap_pin_i, .lin_level_i, .on_switch_level_i,
    .status_pin_level_i, .network_activity_level_i, .super_voltage_status_i,
    .critical_voltage_status_i, .low_voltage_status_i,
    .reset_monitored_supply_ok_i, .low_threshold_select_i,
    .critical_threshold_select_i, .temperature_cross_i,
    .switch_power_event_i, .network_wake_cause_i, .general_reset_delay_i,
    .flag_clear_i, .wake_permit_o, .wake_min_threshold_sel_o,
    .wake_upper_bound_en_o, .power_applied_event_o,
    .network_detector_powerdown_o, .host_reset_n_o, .event_flags_o,
    .host_irq_n_o);

  host_model host (.clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wr_o(reg_wr_i), .wdata_o(reg_wdata_i), .rd_o(reg_rd_i));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic t_regs();
    logic [7:0] d;
    host.rd(8'h08, d);
    chk(d, 8'hE7);
    chk(8'(wake_min_threshold_sel_o), 8'h02);
    host.rd(8'h09, d);
    chk(d, 8'h5F);
    host.wr(8'h08, 8'hFF);
    host.wr(8'h09, 8'hFF);
    host.rd(8'h08, d);
    chk(d, 8'hF7);
    chk(8'(network_detector_powerdown_o), 8'h01);
    host.rd(8'h09, d);
    chk(d, 8'h5F);
    host.wr(8'h08, 8'h00);
    host.rd(8'h08, d);
    chk(d, 8'h00);
    chk(8'(wake_min_threshold_sel_o), 8'h01);
    chk(8'(wake_upper_bound_en_o), 8'h01);
    host.rd(8'h0A, d);
    chk(d, 8'h00);
  endtask

  task automatic t_irq(input int b);
    host.wr(8'h09, 8'h5F);
    flag_clear_i <= 8'hFF;
    @(posedge clk_i);
    flag_clear_i <= 8'h00;
    case (b)
      6: lin_level_i <= ~lin_level_i;
      4: on_switch_level_i <= ~on_switch_level_i;
      3: status_pin_level_i <= ~status_pin_level_i;
      2: network_activity_level_i <= ~network_activity_level_i;
      1: temperature_cross_i <= 1'b1;
      default: low_voltage_status_i <= ~low_voltage_status_i;
    endcase
    @(posedge clk_i);
    temperature_cross_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(event_flags_o & 8'h5F, 8'h01 << b);
    chk(8'(host_irq_n_o), 8'h01);
    host.wr(8'h09, 8'h5F & ~(8'h01 << b));
    repeat (2) @(posedge clk_i);
    chk(8'(host_irq_n_o), 8'h00);
  endtask

  task automatic t_stp(input logic dis);
    host.wr(8'h08, {1'b0, dis, 6'h00});
    @(posedge clk_i);
    switch_power_event_i <= 1'b1;
    @(posedge clk_i);
    switch_power_event_i <= 1'b0;
    #1;
    chk(8'(power_applied_event_o), {7'h00, ~dis});
  endtask

  task automatic t_rst(input logic nc, input logic [2:0] code);
    int n;
    int e;
    host.wr(8'h08, {5'h00, code});
    network_wake_cause_i <= nc;
    general_reset_delay_i <= ~code;
    reset_monitored_supply_ok_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(8'(host_reset_n_o), 8'h00);
    reset_monitored_supply_ok_i <= 1'b1;
    // table entry is the selected code plus 3, then 2 sync edges and 1 load edge
    e = (nc ? int'(code) : int'(3'(~code))) + 6;
    n = 0;
    while (host_reset_n_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(8'(n), 8'(e));
  endtask

  task automatic t_wake();
    host.wr(8'h08, 8'h80);
    critical_voltage_status_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(8'(wake_permit_o), 8'h00);
    host.wr(8'h08, 8'h20);
    repeat (2) @(posedge clk_i);
    chk(8'(wake_permit_o), 8'h01);
    critical_voltage_status_i <= 1'b0;
    super_voltage_status_i <= 1'b1;
    host.wr(8'h08, 8'h00);
    repeat (4) @(posedge clk_i);
    chk(8'(wake_permit_o), 8'h00);
    host.wr(8'h08, 8'h20);
    repeat (2) @(posedge clk_i);
    chk(8'(wake_permit_o), 8'h01);
    super_voltage_status_i <= 1'b0;
  endtask

  // mid-run reset with the strap grounded and the low level pin high
  task automatic t_strap();
    logic [7:0] d;
    wake_level_strap_pin_i <= 1'b0;
    srst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    host.rd(8'h08, d);
    chk(d, 8'h67);
    chk(event_flags_o, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    t_regs();
    t_wake();
    for (int i = 0; i < 7; i++)
      if (i != 5) t_irq(i);
    t_stp(1'b1);
    t_stp(1'b0);
    t_rst(1'b1, 3'h0);
    t_rst(1'b1, 3'h5);
    t_rst(1'b0, 3'h5);
    t_strap();
    give_verdict();
  end

  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
endmodule
